/* File: hw/gcr_pkg.sv */
package gcr_pkg;

	//--------------------------------------------------
	// Clock and timing
	//--------------------------------------------------
	localparam int CLK_PERIOD_NS   = 40;
	localparam int CYC_PER_US_DFLT = 1000 / CLK_PERIOD_NS;
	localparam int SQUELCH_US      = 10;
	localparam int SQUELCH_CYC     = (SQUELCH_US * 1000) / CLK_PERIOD_NS;
	localparam int WAIT_CYC_W      = 20;

	//--------------------------------------------------
	// Crystal wait times in microseconds
	//--------------------------------------------------
	localparam int WAIT_US_1MS   = 1000;
	localparam int WAIT_US_2P5MS = 2500;
	localparam int WAIT_US_5MS   = 5000;
	localparam int WAIT_US_7P5MS = 7500;
	localparam int WAIT_US_10MS  = 10000;
	localparam int WAIT_US_0P5MS = 500;
	localparam int WAIT_US_15MS  = 15000;

	typedef enum logic [2:0] {
		WAIT_1MS   = 3'b000,
		WAIT_2P5MS = 3'b001,
		WAIT_5MS   = 3'b010,
		WAIT_7P5MS = 3'b011,
		WAIT_10MS  = 3'b100,
		WAIT_0P5MS = 3'b101,
		WAIT_15MS  = 3'b110,
		WAIT_RSVD  = 3'b111
	} gcr_wait_code_t;

	//--------------------------------------------------
	// Register byte addresses and fields
	//--------------------------------------------------
	localparam logic [7:0] ADDR_TAG_LO = 8'h00;
	localparam logic [7:0] ADDR_TAG_HI = 8'h01;
	localparam logic [7:0] ADDR_SETUP  = 8'h02;
	localparam logic [7:0] ADDR_RSTCMD = 8'h03;

	localparam int SETUP_LDO_BIT   = 7;
	localparam int SETUP_WAIT_LSB  = 4;
	localparam int SETUP_SEL_LSB   = 0;
	localparam int RST_SETB_BIT    = 5;
	localparam int RST_OE_BIT      = 4;
	localparam int RST_SYNC_BIT    = 1;
	localparam int RST_RESTART_BIT = 0;

	localparam logic [15:0] TAG_RST     = 16'h0000;
	localparam logic        LDO_RST     = 1'b0;
	localparam logic [2:0]  WAIT_RST    = 3'h0;
	localparam logic [3:0]  SEL_RST     = 4'h4;
	localparam logic        SETB_RST    = 1'b1;
	localparam logic        OE_RST      = 1'b1;
	localparam logic        SYNC_RST    = 1'b0;
	localparam logic        RESTART_RST = 1'b0;

	//--------------------------------------------------
	// Carriers
	//--------------------------------------------------
	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} gcr_reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] tag;
	} gcr_otp_load_t;

	function automatic int gcrWaitUs(input logic [2:0] code);
		case (code)
			WAIT_2P5MS: gcrWaitUs = WAIT_US_2P5MS;
			WAIT_5MS:   gcrWaitUs = WAIT_US_5MS;
			WAIT_7P5MS: gcrWaitUs = WAIT_US_7P5MS;
			WAIT_10MS:  gcrWaitUs = WAIT_US_10MS;
			WAIT_0P5MS: gcrWaitUs = WAIT_US_0P5MS;
			WAIT_15MS:  gcrWaitUs = WAIT_US_15MS;
			default:    gcrWaitUs = WAIT_US_1MS;
		endcase
	endfunction

endpackage

/* File: hw/gcr_squelch_timer.sv */
module gcr_squelch_timer
	import gcr_pkg::*;
#(
	parameter int CYCLES = SQUELCH_CYC,
	parameter int CNT_W  = $clog2(CYCLES + 1)
) (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic start,
	output logic      squelch
);

	logic [CNT_W-1:0] cnt_r;
	logic             squelch_r;
	logic [CNT_W:0]   len_r;

	//--------------------------------------------------
	// Squelch window
	//--------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt_r     <= '0;
			squelch_r <= 1'b0;
		end else if (start) begin
			cnt_r     <= CNT_W'(CYCLES - 1);
			squelch_r <= 1'b1;
		end else if (squelch_r) begin
			if (cnt_r == '0) begin
				squelch_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	assign squelch = squelch_r;

	//--------------------------------------------------
	// Checks
	//--------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			len_r <= '0;
		end else if (start) begin
			len_r <= (CNT_W+1)'(1);
		end else if (squelch_r) begin
			len_r <= len_r + 1'b1;
		end
	end

	squelch_len_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(squelch_r) |-> $past(len_r) == (CNT_W+1)'(CYCLES))
		else $error("squelch window length wrong");

	squelch_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
		start |=> squelch_r [*2])
		else $error("squelch did not start");

	squelch_end_c: cover property (@(posedge mclk) disable iff (!rst_b)
		$fell(squelch_r));

endmodule // gcr_squelch_timer

/* File: hw/gcr_global_config.sv */
module gcr_global_config
	import gcr_pkg::*;
#(
	parameter int CYC_PER_US = CYC_PER_US_DFLT
) (
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire gcr_reg_req_t           regReq,
	input  wire gcr_otp_load_t          otpLoad,
	output logic [7:0]                  regRdData,
	output logic                        regRdValid,
	output logic [15:0]                 factoryTag,
	output logic                        ldoHighSel,
	output logic [2:0]                  crystalWaitSel,
	output logic [WAIT_CYC_W-1:0]       crystalWaitCycles,
	output logic [3:0]                  userCfgSel,
	output logic                        inDivSet_b,
	output logic                        outEnable,
	output logic                        divSyncPulse,
	output logic                        apllRestartPulse,
	output logic                        clkSquelch
);

	localparam int US_1MS   = WAIT_US_1MS;
	localparam int US_2P5MS = WAIT_US_2P5MS;

	logic [15:0]           tag_r;
	logic                  ldo_r;
	logic [2:0]            wait_r;
	logic [3:0]            sel_r;
	logic                  setb_r;
	logic                  oe_r;
	logic                  syncBit_r;
	logic                  restartBit_r;
	logic                  syncPrev_r;
	logic                  restartPrev_r;
	logic                  divSyncPulse_r;
	logic                  apllRestartPulse_r;
	logic [WAIT_CYC_W-1:0] waitCyc_r;
	logic [7:0]            rdData_r;
	logic                  rdValid_r;
	logic                  syncRise;
	logic                  restartRise;

	function automatic logic isWrite(input gcr_reg_req_t req,
		input logic [7:0] addr);
		isWrite = req.wrEn && (req.addr == addr);
	endfunction

	//--------------------------------------------------
	// Factory tag
	//--------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tag_r <= TAG_RST;
		end else if (otpLoad.valid) begin
			tag_r <= otpLoad.tag;
		end else if (isWrite(regReq, ADDR_TAG_LO)) begin
			tag_r[7:0] <= regReq.wrData;
		end else if (isWrite(regReq, ADDR_TAG_HI)) begin
			tag_r[15:8] <= regReq.wrData;
		end
	end

	//--------------------------------------------------
	// Device setup
	//--------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ldo_r  <= LDO_RST;
			wait_r <= WAIT_RST;
			sel_r  <= SEL_RST;
		end else if (isWrite(regReq, ADDR_SETUP)) begin
			ldo_r  <= regReq.wrData[SETUP_LDO_BIT];
			wait_r <= regReq.wrData[SETUP_WAIT_LSB +: 3];
			sel_r  <= regReq.wrData[SETUP_SEL_LSB +: 4];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			waitCyc_r <= '0;
		end else begin
			waitCyc_r <= WAIT_CYC_W'(gcrWaitUs(wait_r) * CYC_PER_US);
		end
	end

	//--------------------------------------------------
	// Reset commands
	//--------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			setb_r       <= SETB_RST;
			oe_r         <= OE_RST;
			syncBit_r    <= SYNC_RST;
			restartBit_r <= RESTART_RST;
		end else if (isWrite(regReq, ADDR_RSTCMD)) begin
			setb_r       <= regReq.wrData[RST_SETB_BIT];
			oe_r         <= regReq.wrData[RST_OE_BIT];
			syncBit_r    <= regReq.wrData[RST_SYNC_BIT];
			restartBit_r <= regReq.wrData[RST_RESTART_BIT];
		end
	end

	//--------------------------------------------------
	// Trigger pulses
	//--------------------------------------------------
	assign syncRise    = syncBit_r && !syncPrev_r;
	assign restartRise = restartBit_r && !restartPrev_r;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			syncPrev_r         <= SYNC_RST;
			restartPrev_r      <= RESTART_RST;
			divSyncPulse_r     <= 1'b0;
			apllRestartPulse_r <= 1'b0;
		end else begin
			syncPrev_r         <= syncBit_r;
			restartPrev_r      <= restartBit_r;
			divSyncPulse_r     <= syncRise || restartRise;
			apllRestartPulse_r <= restartRise;
		end
	end

	gcr_squelch_timer #(
		.CYCLES (SQUELCH_CYC)
	) uSquelch (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.start   (divSyncPulse_r),
		.squelch (clkSquelch)
	);

	//--------------------------------------------------
	// Read port
	//--------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rdData_r  <= 8'h00;
			rdValid_r <= 1'b0;
		end else begin
			rdValid_r <= regReq.rdEn;
			if (!regReq.rdEn) begin
				rdData_r <= rdData_r;
			end else if (regReq.addr == ADDR_TAG_LO) begin
				rdData_r <= tag_r[7:0];
			end else if (regReq.addr == ADDR_TAG_HI) begin
				rdData_r <= tag_r[15:8];
			end else if (regReq.addr == ADDR_SETUP) begin
				rdData_r <= {ldo_r, wait_r, sel_r};
			end else if (regReq.addr == ADDR_RSTCMD) begin
				rdData_r <= {2'h0, setb_r, oe_r, 2'h0, syncBit_r,
					restartBit_r};
			end else begin
				rdData_r <= 8'h00;
			end
		end
	end

	assign regRdData         = rdData_r;
	assign regRdValid        = rdValid_r;
	assign factoryTag        = tag_r;
	assign ldoHighSel        = ldo_r;
	assign crystalWaitSel    = wait_r;
	assign crystalWaitCycles = waitCyc_r;
	assign userCfgSel        = sel_r;
	assign inDivSet_b        = setb_r;
	assign outEnable         = oe_r;
	assign divSyncPulse      = divSyncPulse_r;
	assign apllRestartPulse  = apllRestartPulse_r;

	//--------------------------------------------------
	// Checks
	//--------------------------------------------------
	tag_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(!rst_b) |-> factoryTag == 16'h0000)
		else $error("tag not zero after reset");

	otp_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
		otpLoad.valid |=> factoryTag == $past(otpLoad.tag))
		else $error("otp tag not loaded");

	tag_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(!otpLoad.valid && isWrite(regReq, ADDR_TAG_HI))
		|=> factoryTag[15:8] == $past(regReq.wrData))
		else $error("tag high byte not written");

	setup_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(!rst_b) |-> userCfgSel == 4'h4 && !ldoHighSel
		&& crystalWaitSel == 3'h0)
		else $error("setup reset values wrong");

	setup_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
		isWrite(regReq, ADDR_SETUP) |=> ldoHighSel == $past(regReq.wrData[7])
		&& userCfgSel == $past(regReq.wrData[3:0]))
		else $error("setup write lost");

	wait_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(crystalWaitSel == 3'h1) [*2] |-> crystalWaitCycles
		== WAIT_CYC_W'(US_2P5MS * CYC_PER_US))
		else $error("crystal wait count wrong");

	wait_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(crystalWaitSel == 3'h7) [*2] |-> crystalWaitCycles
		== WAIT_CYC_W'(US_1MS * CYC_PER_US))
		else $error("reserved wait code count wrong");

	cmd_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(!rst_b) |-> inDivSet_b && outEnable)
		else $error("command reset values wrong");

	sync_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(isWrite(regReq, ADDR_RSTCMD) && regReq.wrData[1] && !syncBit_r)
		|=> ##1 divSyncPulse ##1 !divSyncPulse ##1 clkSquelch)
		else $error("sync write gave no single pulse");

	no_retrig_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(syncBit_r && syncPrev_r && !restartRise) |=> !divSyncPulse)
		else $error("held sync bit retriggered");

	restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
		restartRise |=> apllRestartPulse && divSyncPulse)
		else $error("restart did not trigger sequence");

	sync_seen_c: cover property (@(posedge mclk) disable iff (!rst_b)
		divSyncPulse && !apllRestartPulse);

	restart_seen_c: cover property (@(posedge mclk) disable iff (!rst_b)
		apllRestartPulse);

	otp_seen_c: cover property (@(posedge mclk) disable iff (!rst_b)
		otpLoad.valid && isWrite(regReq, ADDR_TAG_LO));

endmodule // gcr_global_config

/* File: verification/global_config_reset_controls_bench.sv */
module global_config_reset_controls_bench
	import gcr_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	//--------------------------------------------------
	// Signals
	//--------------------------------------------------
	localparam int CPU = 2;

	logic                  mclk;
	logic                  rst_b;
	gcr_reg_req_t          regReq;
	gcr_otp_load_t         otpLoad;
	logic [7:0]            regRdData;
	logic                  regRdValid;
	logic [15:0]           factoryTag;
	logic                  ldoHighSel;
	logic [2:0]            crystalWaitSel;
	logic [WAIT_CYC_W-1:0] crystalWaitCycles;
	logic [3:0]            userCfgSel;
	logic                  inDivSet_b;
	logic                  outEnable;
	logic                  divSyncPulse;
	logic                  apllRestartPulse;
	logic                  clkSquelch;
	int                    miscompares;
	int                    comparisons;
	int                    syncCnt = 0;
	int                    restartCnt = 0;
	int                    waitUs [8] = '{1000, 2500, 5000, 7500, 10000,
		500, 15000, 1000};

	gcr_global_config #(.CYC_PER_US(CPU)) dut (
		.mclk              (mclk),
		.rst_b             (rst_b),
		.regReq            (regReq),
		.otpLoad           (otpLoad),
		.regRdData         (regRdData),
		.regRdValid        (regRdValid),
		.factoryTag        (factoryTag),
		.ldoHighSel        (ldoHighSel),
		.crystalWaitSel    (crystalWaitSel),
		.crystalWaitCycles (crystalWaitCycles),
		.userCfgSel        (userCfgSel),
		.inDivSet_b        (inDivSet_b),
		.outEnable         (outEnable),
		.divSyncPulse      (divSyncPulse),
		.apllRestartPulse  (apllRestartPulse),
		.clkSquelch        (clkSquelch)
	);

	always #20 mclk = ~mclk;

	// Pulse counters
	always @(posedge mclk) begin
		if (divSyncPulse === 1'b1) syncCnt++;
		if (apllRestartPulse === 1'b1) restartCnt++;
	end

	//--------------------------------------------------
	// Tasks
	//--------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk);
		regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: addr, wrData: data};
		@(posedge mclk);
		regReq <= '0;
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge mclk);
		regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: addr, wrData: 8'h00};
		@(posedge mclk);
		regReq <= '0;
		#1;
		chk("regRdValid", 32'h1, regRdValid);
		chk("regRdData", exp, regRdData);
	endtask

	task automatic squelchLen(input int exp);
		int n;
		n = 0;
		while (clkSquelch === 1'b1 && n < 400) begin
			n++;
			@(posedge mclk);
			#1;
		end
		chk("squelch cycles", exp, n);
	endtask

	task automatic end_sim;
		$display("Counts: comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	//--------------------------------------------------
	// Watchdog
	//--------------------------------------------------
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		$display("[FAIL] run length expected finish seen timeout");
		end_sim();
	end

	//--------------------------------------------------
	// Sequence
	//--------------------------------------------------
	initial begin
		int s;
		int r;
		mclk = 1'b0;
		rst_b = 1'b0;
		regReq = '0;
		otpLoad = '0;
		miscompares = 0;
		comparisons = 0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		#1;
		chk("factoryTag", 32'h0, factoryTag);
		chk("ldoHighSel", 32'h0, ldoHighSel);
		chk("inDivSet_b", 32'h1, inDivSet_b);
		chk("outEnable", 32'h1, outEnable);
		rd(ADDR_TAG_HI, 8'h00);
		rd(ADDR_SETUP, 8'h04);
		rd(ADDR_RSTCMD, 8'h30);
		rd(8'h07, 8'h00);
		$display("Test reset values done");

		wr(ADDR_TAG_LO, 8'h5a);
		wr(ADDR_TAG_HI, 8'hc3);
		#1;
		chk("factoryTag", 32'hc35a, factoryTag);
		rd(ADDR_TAG_LO, 8'h5a);
		@(posedge mclk);
		otpLoad <= '{valid: 1'b1, tag: 16'h1234};
		regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: ADDR_TAG_LO,
			wrData: 8'haa};
		@(posedge mclk);
		otpLoad <= '0;
		regReq <= '0;
		#1;
		chk("factoryTag", 32'h1234, factoryTag);
		$display("Test tag done");

		for (int c = 0; c < 8; c++) begin
			wr(ADDR_SETUP, {1'b1, c[2:0], 4'(c)});
			@(posedge mclk);
			#1;
			chk("crystalWaitCycles", waitUs[c] * CPU, crystalWaitCycles);
			chk("crystalWaitSel", c, crystalWaitSel);
			chk("ldoHighSel", 32'h1, ldoHighSel);
			chk("userCfgSel", c, userCfgSel);
		end
		wr(ADDR_SETUP, 8'h04);
		rd(ADDR_SETUP, 8'h04);
		$display("Test setup done");

		wr(ADDR_RSTCMD, 8'h00);
		#1;
		chk("inDivSet_b", 32'h0, inDivSet_b);
		chk("outEnable", 32'h0, outEnable);
		wr(ADDR_RSTCMD, 8'hcc);
		rd(ADDR_RSTCMD, 8'h00);
		wr(ADDR_RSTCMD, 8'h32);
		@(posedge mclk);
		#1;
		chk("divSyncPulse", 32'h1, divSyncPulse);
		chk("apllRestartPulse", 32'h0, apllRestartPulse);
		chk("outEnable", 32'h1, outEnable);
		@(posedge mclk);
		#1;
		chk("divSyncPulse", 32'h0, divSyncPulse);
		squelchLen(250);
		s = syncCnt;
		wr(ADDR_RSTCMD, 8'h32);
		repeat (6) @(posedge mclk);
		#1;
		chk("repeat sync count", s, syncCnt);
		$display("Test sync done");

		r = restartCnt;
		wr(ADDR_RSTCMD, 8'h30);
		wr(ADDR_RSTCMD, 8'h31);
		@(posedge mclk);
		#1;
		chk("apllRestartPulse", 32'h1, apllRestartPulse);
		chk("divSyncPulse", 32'h1, divSyncPulse);
		@(posedge mclk);
		#1;
		chk("restart count", r + 1, restartCnt);
		chk("sync count", s + 1, syncCnt);
		squelchLen(250);
		$display("Test restart done");

		wr(ADDR_RSTCMD, 8'h32);
		repeat (4) @(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		#1;
		chk("factoryTag", 32'h0, factoryTag);
		chk("clkSquelch", 32'h0, clkSquelch);
		chk("userCfgSel", 32'h4, userCfgSel);
		rd(ADDR_RSTCMD, 8'h30);
		chk("divSyncPulse", 32'h0, divSyncPulse);
		chk("apllRestartPulse", 32'h0, apllRestartPulse);
		$display("Test second reset done");
		end_sim();
	end

endmodule // global_config_reset_controls_bench
